// ==== design/counter3_pkg.sv ====
// Purpose: shared constants for the 16-bit up-counter block
// Assumes: 50 MHz aclk, AXI4-Lite register access, 32-bit data
// Notes:   registers sit in byte lane 0 of each aligned word
package counter3_pkg;
  localparam int          ADDR_W          = 8;
  localparam int          CLK_PERIOD_NS   = 20;
  localparam int          FOSC_DIVIDE     = 4;
  localparam int          LP_OSC_MAX_KHZ  = 200;
  localparam int          LP_OSC_MIN_CYC  = (1_000_000 / LP_OSC_MAX_KHZ) / CLK_PERIOD_NS;

  localparam logic [7:0]  ADDR_CONTROL    = 8'h00;
  localparam logic [7:0]  ADDR_COUNT_LOW  = 8'h04;
  localparam logic [7:0]  ADDR_COUNT_HIGH = 8'h08;
  localparam logic [7:0]  ADDR_IRQ_STATUS = 8'h0c;
  localparam logic [7:0]  ADDR_IRQ_MASK   = 8'h10;
  localparam logic [7:0]  ADDR_AUX        = 8'h14;

  localparam logic [2:0]  IDX_CONTROL     = 3'h0;
  localparam logic [2:0]  IDX_LOW         = 3'h1;
  localparam logic [2:0]  IDX_HIGH        = 3'h2;
  localparam logic [2:0]  IDX_STATUS      = 3'h3;
  localparam logic [2:0]  IDX_MASK        = 3'h4;
  localparam logic [2:0]  IDX_AUX         = 3'h5;
  localparam logic [2:0]  IDX_NONE        = 3'h7;

  // control, aux and interrupt register field positions
  localparam int          CTL_WIDE        = 7;
  localparam int          CTL_ASSIGN_HI   = 6;
  localparam int          CTL_PRE_HI      = 5;
  localparam int          CTL_PRE_LO      = 4;
  localparam int          CTL_ASSIGN_LO   = 3;
  localparam int          CTL_SYNC_BYPASS = 2;
  localparam int          CTL_SRC         = 1;
  localparam int          CTL_RUN         = 0;
  localparam int          AUX_OSC_EN      = 0;
  localparam int          IRQ_OVERFLOW    = 0;

  localparam logic [7:0]  CONTROL_RESET   = 8'h00;
  localparam logic [15:0] COUNT_RESET     = 16'h0000;
  localparam logic [15:0] COUNT_MAX       = 16'hffff;
  localparam logic [3:0]  MODE_SPECIAL    = 4'hb;
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;

  typedef enum logic [1:0] {WR_IDLE = 2'b01, WR_RESP = 2'b10} wr_state_t;
  typedef enum logic [1:0] {RD_IDLE = 2'b01, RD_DATA = 2'b10} rd_state_t;
endpackage : counter3_pkg

// ==== design/count_edge_source.sv ====
// Purpose: count source, internal quarter-rate tick or external rising edges
// Assumes: external levels sampled on aclk
// Notes:   bypass path trades metastability safety for two fewer cycles of latency
`timescale 1ns/1ps
module count_edge_source (
  input  logic aclk,
  input  logic aresetn,
  input  logic source_ext,
  input  logic sync_bypass,
  input  logic low_power_osc_enable,
  input  logic lp_osc_clk,
  input  logic external_count_pin,
  input  logic arm_clear,
  output logic src_tick
);
  import counter3_pkg::*;

  logic [1:0] div_cnt;
  logic       fosc4_tick;
  logic       ext_level;
  logic       sync1;
  logic       sync2;
  logic       prev_sync;
  logic       prev_raw;
  logic       level;
  logic       prev;
  logic       armed;

  assign fosc4_tick = (div_cnt == 2'(FOSC_DIVIDE - 1));
  assign ext_level  = low_power_osc_enable ? lp_osc_clk : external_count_pin;
  assign level      = sync_bypass ? ext_level : sync2;
  assign prev       = sync_bypass ? prev_raw : prev_sync;
  // internal source ignores the bypass bit completely
  assign src_tick   = source_ext ? (armed & level & ~prev) : fosc4_tick;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_cnt <= 2'h0;
    end else begin
      div_cnt <= div_cnt + 2'h1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1     <= 1'b0;
      sync2     <= 1'b0;
      prev_sync <= 1'b0;
      prev_raw  <= 1'b0;
    end else begin
      sync1     <= ext_level;
      sync2     <= sync1;
      prev_sync <= sync2;
      prev_raw  <= ext_level;
    end
  end

  // first counted edge is the rise after the first fall
  always_ff @(posedge aclk) begin
    if (!aresetn || arm_clear || !source_ext) begin
      armed <= 1'b0;
    end else if (~level & prev) begin
      armed <= 1'b1;
    end
  end

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  internal_rate_a: assert property (!source_ext && src_tick |=> !src_tick [*3])
    else $error("internal tick faster than a quarter of the clock");
  first_edge_a: assert property ($rose(armed) |-> $past(!level && prev))
    else $error("external edge counting armed without a falling edge");
endmodule : count_edge_source

// ==== design/counter3_prescale.sv ====
// Purpose: 1:1 to 1:8 prescaler ahead of the counter
// Assumes: tick_in is a one-cycle pulse
// Notes:   cleared on count or control writes so a new setting starts clean
`timescale 1ns/1ps
module counter3_prescale #(
  parameter int STAGE_BITS = 3
) (
  input  logic       aclk,
  input  logic       aresetn,
  input  logic       clear,
  input  logic       tick_in,
  input  logic [1:0] select,
  output logic       tick_out
);
  import counter3_pkg::*;

  logic [STAGE_BITS-1:0] cnt;
  logic [STAGE_BITS-1:0] limit;

  if (STAGE_BITS < 3) begin : g_check
    $error("prescaler needs at least three stages for 1:8");
  end

  assign limit    = STAGE_BITS'((1 << select) - 1);
  assign tick_out = tick_in && (cnt == limit);

  always_ff @(posedge aclk) begin
    if (!aresetn || clear) begin
      cnt <= '0;
    end else if (tick_in) begin
      cnt <= tick_out ? '0 : cnt + 1'b1;
    end
  end

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  prescale_gap_a: assert property (tick_out && select != 2'h0 && !clear |=> !tick_out)
    else $error("prescaled tick repeated back to back");
endmodule : counter3_prescale

// ==== design/timer3_counter16.sv ====
// Purpose: 16-bit up-counter with prescaler, overflow interrupt and AXI4-Lite registers
// Assumes: single 50 MHz clock, synchronous active-low reset, inputs synchronous
// Notes:   one write and one read in flight; answers are registered
//
// Local design decisions: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
module timer3_counter16 #(
  parameter int PRESCALE_BITS = 3
) (
  input  logic                            aclk,
  input  logic                            aresetn,
  input  logic [counter3_pkg::ADDR_W-1:0] awaddr,
  input  logic                            awvalid,
  output logic                            awready,
  input  logic [31:0]                     wdata,
  input  logic [3:0]                      wstrb,
  input  logic                            wvalid,
  output logic                            wready,
  output logic [1:0]                      bresp,
  output logic                            bvalid,
  input  logic                            bready,
  input  logic [counter3_pkg::ADDR_W-1:0] araddr,
  input  logic                            arvalid,
  output logic                            arready,
  output logic [31:0]                     rdata,
  output logic [1:0]                      rresp,
  output logic                            rvalid,
  input  logic                            rready,
  input  logic                            external_count_pin,
  input  logic                            lp_osc_clk,
  input  logic [1:0]                      port_c_pin_in,
  input  logic [1:0]                      port_c_direction,
  output logic [1:0]                      port_c_drive_en,
  output logic [1:0]                      port_c_read,
  input  logic [1:0]                      compare_trigger,
  input  logic [3:0]                      compare_mode_field_one,
  input  logic [3:0]                      compare_mode_field_two,
  output logic [4:0]                      module_uses_counter3,
  output logic                            overflow_irq
);
  import counter3_pkg::*;

  function automatic logic [2:0] reg_index(input logic [ADDR_W-1:0] a);
    case (a)
      ADDR_CONTROL:    reg_index = IDX_CONTROL;
      ADDR_COUNT_LOW:  reg_index = IDX_LOW;
      ADDR_COUNT_HIGH: reg_index = IDX_HIGH;
      ADDR_IRQ_STATUS: reg_index = IDX_STATUS;
      ADDR_IRQ_MASK:   reg_index = IDX_MASK;
      ADDR_AUX:        reg_index = IDX_AUX;
      default:         reg_index = IDX_NONE;
    endcase
  endfunction : reg_index

  wr_state_t         wr_state;
  rd_state_t         rd_state;
  logic              aw_have;
  logic              w_have;
  logic [ADDR_W-1:0] aw_addr;
  logic [7:0]        w_byte;
  logic              w_lane0;
  logic              wr_fire;
  logic [2:0]        wr_idx;
  logic [2:0]        rd_idx;
  logic [7:0]        rd_value;

  logic [7:0]        control;
  logic [15:0]       count;
  logic [15:0]       next_count;
  logic [7:0]        high_read_buf;
  logic [7:0]        high_write_stage;
  logic              overflow_flag;
  logic              overflow_irq_enable;
  logic              low_power_osc_enable;

  logic              wide_access_select;
  logic [1:0]        module_timer_assign;
  logic [1:0]        input_prescale;
  logic              ext_sync_bypass;
  logic              count_source_select;
  logic              counter_run;

  logic              ctl_wr;
  logic              cnt_wr_low;
  logic              cnt_wr_high;
  logic              cnt_wr;
  logic              trig_clear;
  logic              src_tick;
  logic              pre_tick;
  logic              inc;
  logic              wrap;

  assign wide_access_select  = control[CTL_WIDE];
  assign module_timer_assign = {control[CTL_ASSIGN_HI], control[CTL_ASSIGN_LO]};
  assign input_prescale      = control[CTL_PRE_HI:CTL_PRE_LO];
  assign ext_sync_bypass     = control[CTL_SYNC_BYPASS];
  assign count_source_select = control[CTL_SRC];
  assign counter_run         = control[CTL_RUN];

  // write channel: address and data taken in either order, acted on together
  assign awready = (wr_state == WR_IDLE) && !aw_have;
  assign wready  = (wr_state == WR_IDLE) && !w_have;
  assign bvalid  = (wr_state == WR_RESP);
  assign wr_fire = (wr_state == WR_IDLE) && aw_have && w_have;
  assign wr_idx  = reg_index(aw_addr);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_state <= WR_IDLE;
      aw_have  <= 1'b0;
      w_have   <= 1'b0;
      aw_addr  <= '0;
      w_byte   <= 8'h00;
      w_lane0  <= 1'b0;
      bresp    <= RESP_OKAY;
    end else begin
      case (wr_state)
        WR_IDLE: begin
          if (awvalid && awready) begin
            aw_have <= 1'b1;
            aw_addr <= awaddr;
          end
          if (wvalid && wready) begin
            w_have  <= 1'b1;
            w_byte  <= wdata[7:0];
            w_lane0 <= wstrb[0];
          end
          if (wr_fire) begin
            wr_state <= WR_RESP;
            aw_have  <= 1'b0;
            w_have   <= 1'b0;
            bresp    <= (wr_idx == IDX_NONE) ? RESP_SLVERR : RESP_OKAY;
          end
        end
        WR_RESP: begin
          if (bready) begin
            wr_state <= WR_IDLE;
          end
        end
        default: wr_state <= WR_IDLE;
      endcase
    end
  end

  // read channel: data registered on the same edge that takes the address
  assign arready = (rd_state == RD_IDLE);
  assign rvalid  = (rd_state == RD_DATA);
  assign rd_idx  = reg_index(araddr);

  always_comb begin
    case (rd_idx)
      IDX_CONTROL: rd_value = control;
      IDX_LOW:     rd_value = count[7:0];
      IDX_HIGH:    rd_value = wide_access_select ? high_read_buf : count[15:8];
      IDX_STATUS:  rd_value = 8'({overflow_flag});
      IDX_MASK:    rd_value = 8'({overflow_irq_enable});
      IDX_AUX:     rd_value = 8'({low_power_osc_enable});
      default:     rd_value = 8'h00;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_state <= RD_IDLE;
      rdata    <= 32'h0000_0000;
      rresp    <= RESP_OKAY;
    end else begin
      case (rd_state)
        RD_IDLE: begin
          if (arvalid) begin
            rd_state <= RD_DATA;
            rdata    <= {24'h00_0000, rd_value};
            rresp    <= (rd_idx == IDX_NONE) ? RESP_SLVERR : RESP_OKAY;
          end
        end
        RD_DATA: begin
          if (rready) begin
            rd_state <= RD_IDLE;
          end
        end
        default: rd_state <= RD_IDLE;
      endcase
    end
  end

  // a low-byte read in wide mode freezes the high byte for the next read
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      high_read_buf <= 8'h00;
    end else if (arvalid && arready && rd_idx == IDX_LOW && wide_access_select) begin
      high_read_buf <= count[15:8];
    end
  end

  // configuration registers
  assign ctl_wr = wr_fire && w_lane0 && (wr_idx == IDX_CONTROL);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      control              <= CONTROL_RESET;
      overflow_irq_enable  <= 1'b0;
      low_power_osc_enable <= 1'b0;
    end else if (wr_fire && w_lane0) begin
      if (wr_idx == IDX_CONTROL) begin
        control <= w_byte;
      end
      if (wr_idx == IDX_MASK) begin
        overflow_irq_enable <= w_byte[IRQ_OVERFLOW];
      end
      if (wr_idx == IDX_AUX) begin
        low_power_osc_enable <= w_byte[AUX_OSC_EN];
      end
    end
  end

  // count path
  assign cnt_wr_low  = wr_fire && w_lane0 && (wr_idx == IDX_LOW);
  assign cnt_wr_high = wr_fire && w_lane0 && (wr_idx == IDX_HIGH);
  assign cnt_wr      = cnt_wr_low || (cnt_wr_high && !wide_access_select);
  assign trig_clear  = (compare_trigger[0] && compare_mode_field_one == MODE_SPECIAL) ||
                       (compare_trigger[1] && compare_mode_field_two == MODE_SPECIAL);
  assign inc         = counter_run && pre_tick;
  assign wrap        = inc && (count == COUNT_MAX) && !cnt_wr && !trig_clear;

  count_edge_source u_source (
    .aclk                 (aclk),
    .aresetn              (aresetn),
    .source_ext           (count_source_select),
    .sync_bypass          (ext_sync_bypass),
    .low_power_osc_enable (low_power_osc_enable),
    .lp_osc_clk           (lp_osc_clk),
    .external_count_pin   (external_count_pin),
    .arm_clear            (!counter_run),
    .src_tick             (src_tick)
  );

  counter3_prescale #(
    .STAGE_BITS (PRESCALE_BITS)
  ) u_prescale (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .clear    (cnt_wr || ctl_wr),
    .tick_in  (src_tick && counter_run),
    .select   (input_prescale),
    .tick_out (pre_tick)
  );

  // software write first, then trigger clear, then increment
  always_comb begin
    next_count = count;
    if (cnt_wr_low) begin
      next_count = wide_access_select ? {high_write_stage, w_byte} : {count[15:8], w_byte};
    end else if (cnt_wr_high && !wide_access_select) begin
      next_count = {w_byte, count[7:0]};
    end else if (trig_clear) begin
      next_count = COUNT_RESET;
    end else if (inc) begin
      next_count = count + 16'h0001;
    end
  end

  // the count has no defined power-on value; zero is used so simulation stays clean
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count <= COUNT_RESET;
    end else begin
      count <= next_count;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      high_write_stage <= 8'h00;
    end else if (cnt_wr_high && wide_access_select) begin
      high_write_stage <= w_byte;
    end
  end

  // sticky overflow flag, write one to clear, a new wrap wins over the clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      overflow_flag <= 1'b0;
    end else if (wrap) begin
      overflow_flag <= 1'b1;
    end else if (wr_fire && w_lane0 && wr_idx == IDX_STATUS && w_byte[IRQ_OVERFLOW]) begin
      overflow_flag <= 1'b0;
    end
  end

  assign overflow_irq = overflow_flag && overflow_irq_enable;

  // timer assignment and port pins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      module_uses_counter3 <= 5'h00;
      port_c_drive_en      <= 2'h0;
      port_c_read          <= 2'h0;
    end else begin
      case (module_timer_assign)
        2'b11:   module_uses_counter3 <= 5'h1f;
        2'b10:   module_uses_counter3 <= 5'h1c;
        2'b01:   module_uses_counter3 <= 5'h1e;
        default: module_uses_counter3 <= 5'h00;
      endcase
      port_c_drive_en <= low_power_osc_enable ? 2'h0 : ~port_c_direction;
      port_c_read     <= low_power_osc_enable ? 2'h0 : port_c_pin_in;
    end
  end

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  wrap_zero_a: assert property (wrap |=> count == COUNT_RESET && overflow_flag)
    else $error("wrap did not return to zero with flag set");
  count_step_a: assert property (inc && !cnt_wr && !trig_clear && !cnt_wr_high |=>
    count == $past(count) + 16'h0001)
    else $error("count did not step by one");
  irq_gate_a: assert property (overflow_flag && !overflow_irq_enable |-> !overflow_irq)
    else $error("interrupt raised while disabled");
  run_hold_a: assert property (!counter_run && !cnt_wr && !cnt_wr_high && !trig_clear |=>
    count == $past(count))
    else $error("count moved while stopped");
  trig_clear_a: assert property (trig_clear && !cnt_wr_low && !cnt_wr_high |=> count == COUNT_RESET)
    else $error("special trigger did not clear count");
  trig_noflag_a: assert property (trig_clear && !overflow_flag |=> !overflow_flag)
    else $error("trigger clear set the overflow flag");
  write_wins_a: assert property (cnt_wr_low && trig_clear |=> count[7:0] == $past(w_byte))
    else $error("trigger clear beat a count write");
  wide_stage_a: assert property (cnt_wr_high && wide_access_select && !trig_clear && !inc |=>
    count == $past(count))
    else $error("wide high write reached the count early");
  assign_none_a: assert property (module_timer_assign == 2'b00 |=> module_uses_counter3 == 5'h00)
    else $error("assignment 00 left modules on this timer");
  osc_pins_a: assert property (low_power_osc_enable |=> port_c_read == 2'h0 && port_c_drive_en == 2'h0)
    else $error("oscillator pins not forced to input");
endmodule : timer3_counter16

// ==== test/compare_partner.sv ====
// Purpose: far-side model, compare units and external count sources
// Assumes: tasks are called from the bench right after a rising edge
// Notes:   sources idle high so every pulse is a fall followed by a rise
`timescale 1ns/1ps
module compare_partner (
  input  wire logic       aclk,
  output logic      [1:0] compare_trigger,
  output logic      [3:0] mode_one,
  output logic      [3:0] mode_two,
  output logic            count_pin,
  output logic            osc_clk
);
  // shortest legal half period keeps the oscillator at its rated ceiling
  localparam int HALF = counter3_pkg::LP_OSC_MIN_CYC / 2;

  initial begin
    compare_trigger = 2'h0;
    mode_one        = 4'h0;
    mode_two        = 4'h0;
    count_pin       = 1'b1;
    osc_clk         = 1'b1;
  end

  // triggers only while the counter is stopped or synchronized
  task automatic fire(input int unit, input logic [3:0] mode, input int lead);
    if (unit == 0) mode_one <= mode;
    else mode_two <= mode;
    repeat (lead) @(posedge aclk);
    compare_trigger[unit] <= 1'b1;
    @(posedge aclk);
    compare_trigger <= 2'h0;
  endtask : fire

  // parks the count pin at a level, for starts that do not begin high
  task automatic set_pin(input logic v);
    count_pin <= v;
  endtask : set_pin

  // system clock never comes from the oscillator here
  task automatic pulses(input int n, input bit use_osc);
    repeat (n) begin
      if (use_osc) osc_clk <= 1'b0;
      else count_pin <= 1'b0;
      repeat (HALF) @(posedge aclk);
      if (use_osc) osc_clk <= 1'b1;
      else count_pin <= 1'b1;
      repeat (HALF) @(posedge aclk);
    end
  endtask : pulses
endmodule : compare_partner

// ==== test/tb.sv ====
// Purpose: register-level bench for the 16-bit up-counter
// Assumes: no fixed bus latency, tasks wait for each answer; one write and one read outstanding
// Notes:   prescaler phase is unknown, so timed counts allow one tick of slack
`timescale 1ns/1ps
module tb;
  import counter3_pkg::*;
  logic        aclk    = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  awaddr  = 8'h00;
  logic [7:0]  araddr  = 8'h00;
  logic [31:0] wdata   = 32'h0000_0000;
  logic        awvalid = 1'b0;
  logic        wvalid  = 1'b0;
  logic        bready  = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready  = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, irq, pin, osc;
  logic [31:0] rdata, rdv;
  logic [1:0]  bresp, rresp, rs, trig, pdrive, pread;
  logic [3:0]  mode_one, mode_two;
  logic [4:0]  uses;
  logic [7:0]  use_tab [4] = '{8'h00, 8'h1e, 8'h1c, 8'h1f};
  int          fail_count = 0;
  int          checked    = 0;
  int          cyc        = 0;
  int          t0, exp_c;

  always #10 aclk = ~aclk;
  always @(posedge aclk) cyc <= cyc + 1;

  timer3_counter16 timer3_counter16_inst (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(4'h1), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .external_count_pin(pin), .lp_osc_clk(osc),
    .port_c_pin_in(2'h3), .port_c_direction(2'h0), .port_c_drive_en(pdrive), .port_c_read(pread),
    .compare_trigger(trig), .compare_mode_field_one(mode_one), .compare_mode_field_two(mode_two),
    .module_uses_counter3(uses), .overflow_irq(irq));

  compare_partner compare_partner_inst (.aclk(aclk), .compare_trigger(trig), .mode_one(mode_one),
    .mode_two(mode_two), .count_pin(pin), .osc_clk(osc));

  task automatic tally_and_finish();
    if (fail_count == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [31:0] got, input logic [7:0] exp);
    checked++;
    if (got !== {24'h00_0000, exp}) begin
      fail_count++;
      $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic stall(input int n);
    if (n > 200) begin
      fail_count++;
      tally_and_finish();
    end
  endtask : stall

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= {24'h00_0000, d};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      stall(n);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    rs = bresp;
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      stall(n);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rdv = rdata;
    rs  = rresp;
    rready <= 1'b0;
  endtask : rd

  initial begin
    repeat (60000) @(posedge aclk);
    fail_count++;
    tally_and_finish();
  end

  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    rd(ADDR_CONTROL); chk(rdv, 8'h00);
    rd(8'h18); chk({rdv[29:0], rs}, RESP_SLVERR);
    wr(8'h18, 8'hff); chk(32'(rs), RESP_SLVERR);
    for (int c = 0; c < 4; c++) begin
      wr(ADDR_CONTROL, {1'b0, c[1], 2'b00, c[0], 3'b000});
      rd(ADDR_CONTROL); chk(rdv, {1'b0, c[1], 2'b00, c[0], 3'b000});
      chk(32'(uses), use_tab[c]);
    end
    // bypass bit stays set here; internal source must ignore it
    for (int p = 0; p < 4; p++) begin
      wr(ADDR_COUNT_LOW, 8'h00);
      wr(ADDR_CONTROL, 8'h05 | 8'(p << 4));
      t0 = cyc;
      repeat (240) @(posedge aclk);
      wr(ADDR_CONTROL, 8'h00);
      exp_c = (cyc - t0) / (FOSC_DIVIDE << p);
      rd(ADDR_COUNT_LOW);
      chk({31'h0, int'(rdv) >= exp_c - 1 && int'(rdv) <= exp_c + 1}, 8'h01);
      t0 = int'(rdv);
      rd(ADDR_COUNT_LOW); chk(rdv, 8'(t0));
    end
    wr(ADDR_IRQ_MASK, 8'h01);
    wr(ADDR_COUNT_HIGH, 8'hff);
    wr(ADDR_COUNT_LOW, 8'hfe);
    wr(ADDR_CONTROL, 8'h01);
    repeat (40) @(posedge aclk);
    wr(ADDR_CONTROL, 8'h00);
    rd(ADDR_COUNT_HIGH); chk(rdv, 8'h00);
    rd(ADDR_IRQ_STATUS); chk(rdv, 8'h01);
    chk(32'(irq), 8'h01);
    wr(ADDR_IRQ_MASK, 8'h00);
    chk(32'(irq), 8'h00);
    wr(ADDR_IRQ_STATUS, 8'h01);
    rd(ADDR_IRQ_STATUS); chk(rdv, 8'h00);
    for (int k = 0; k < 3; k++) begin
      wr(ADDR_COUNT_LOW, 8'h20);
      compare_partner_inst.fire(k / 2, (k == 0) ? 4'ha : MODE_SPECIAL, 1);
      rd(ADDR_COUNT_LOW); chk(rdv, (k == 0) ? 8'h20 : 8'h00);
    end
    rd(ADDR_IRQ_STATUS); chk(rdv, 8'h00);
    wr(ADDR_CONTROL, 8'h80);
    wr(ADDR_COUNT_HIGH, 8'h12);
    rd(ADDR_COUNT_LOW);
    rd(ADDR_COUNT_HIGH); chk(rdv, 8'h00);
    wr(ADDR_COUNT_LOW, 8'h34);
    rd(ADDR_COUNT_LOW); chk(rdv, 8'h34);
    rd(ADDR_COUNT_HIGH); chk(rdv, 8'h12);
    wr(ADDR_CONTROL, 8'h00);
    // trigger lands on the very edge that applies the write
    fork
      wr(ADDR_COUNT_LOW, 8'h55);
      compare_partner_inst.fire(1, MODE_SPECIAL, 2);
    join
    rd(ADDR_COUNT_LOW); chk(rdv, 8'h55);
    rd(ADDR_COUNT_HIGH); chk(rdv, 8'h12);
    // pin already low at start: its first rise has no fall before it and is not counted
    compare_partner_inst.set_pin(1'b0);
    wr(ADDR_COUNT_LOW, 8'h00);
    wr(ADDR_CONTROL, 8'h03);
    compare_partner_inst.set_pin(1'b1);
    repeat (4) @(posedge aclk);
    compare_partner_inst.pulses(1, 1'b0);
    wr(ADDR_CONTROL, 8'h00);
    rd(ADDR_COUNT_LOW); chk(rdv, 8'h01);
    for (int k = 0; k < 3; k++) begin
      wr(ADDR_AUX, (k == 2) ? 8'h01 : 8'h00);
      wr(ADDR_COUNT_LOW, 8'h00);
      wr(ADDR_CONTROL, (k == 1) ? 8'h07 : 8'h03);
      compare_partner_inst.pulses(5, k == 2);
      wr(ADDR_CONTROL, 8'h00);
      rd(ADDR_COUNT_LOW); chk(rdv, 8'h05);
    end
    chk({28'h000_0000, pread, pdrive}, 8'h00);
    wr(ADDR_AUX, 8'h00);
    @(posedge aclk);
    chk({28'h000_0000, pread, pdrive}, 8'h0f);
    tally_and_finish();
  end
endmodule : tb
